// File: design/srnv_params.svh
// constants for the reset and nmi vector unit: offsets, bit positions, slot counts
// assumes inclusion by bare name from design files
`ifndef SRNV_PARAMS_SVH
`define SRNV_PARAMS_SVH

// register byte addresses
`define SRNV_ADDR_USER_NMI   16'h015a
`define SRNV_ADDR_SYS_NMI    16'h015c
`define SRNV_ADDR_RST_CAUSE  16'h015e

// mailbox addresses
`define SRNV_ADDR_MBOX_OUT   16'h0150
`define SRNV_ADDR_MBOX_IN    16'h0152

`define SRNV_NONE            16'h0000

// reset cause source index (bit position = code/2 - 1)
`define SRNV_RC_BOR          0
`define SRNV_RC_PIN          1
`define SRNV_RC_SWBOR        2
`define SRNV_RC_LPM5         3
`define SRNV_RC_SECV         4
`define SRNV_RC_SVSH         6
`define SRNV_RC_SWPOR        9
`define SRNV_RC_WDT          10
`define SRNV_RC_WDTKEY       11
`define SRNV_RC_NVMKEY       12
`define SRNV_RC_NVMUNC       13
`define SRNV_RC_PERFETCH     14
`define SRNV_RC_PMMKEY       15
`define SRNV_RC_FLL          17

// system nmi source index
`define SRNV_SN_SVSL         0
`define SRNV_SN_NVMUNC       1
`define SRNV_SN_VACANT       8
`define SRNV_SN_MBIN         9
`define SRNV_SN_MBOUT        10
`define SRNV_SN_NVMCOR       11

// user nmi source index
`define SRNV_UN_PIN          0
`define SRNV_UN_OSC          1

// number of priority slots per vector
`define SRNV_RC_SLOTS        31
`define SRNV_SN_SLOTS        15
`define SRNV_UN_SLOTS        15

`endif

// File: design/srnv_pkg.sv
// types for the reset and nmi vector unit
// assumes srnv_params.svh supplies the numbers
package srnv_pkg;
	typedef logic [15:0] srnv_word_t;
	typedef logic [30:0] srnv_rc_vec_t;
	typedef logic [14:0] srnv_nmi_vec_t;
endpackage

// File: design/srnv_prio_enc.sv
// priority encoder: lowest set bit gives the vector code (2*(index+1))
// assumes a pending vector of up to 31 slots from the same clock domain
`timescale 1ns/1ns
`default_nettype none
module srnv_prio_enc #(
	parameter int SLOTS = 31
) (
	// pending sources
	input  wire logic [SLOTS-1:0] pending,
	// encoded answer
	output logic      [15:0]      code,
	output logic      [SLOTS-1:0] oneHot
);
	// scan from the top so the smallest index wins
	always_comb begin
		code = 16'h0000;
		oneHot = '0;
		for (int i = SLOTS - 1; i >= 0; i--) begin
			if (pending[i]) begin
				code = 16'((i + 1) * 2);
				oneHot = SLOTS'(1) << i;
			end
		end
	end
endmodule
`default_nettype wire

// File: design/srnv_top.sv
// reset cause, system nmi and user nmi vector generators with the debug mailbox
// assumes a simple synchronous peripheral bus on sys_clk and same-domain event pulses
//
// Function
// [R01] reset cause reads 02h for supply brownout, 04h for reset pin, 06h for software brownout.
// [R02] reset cause reads 08h for deep wakeup, 0Ah for security fault, 0Eh for high supervisor.
// [R03] reset cause reads 14h after a software power-on request.
// [R04] reset cause reads 16h after watchdog expiry.
// [R05] reset cause reads 18h for a bad watchdog key and 1Ah for a bad nvm controller key.
// [R06] an uncorrectable nvm error posts 1Ch in reset cause and 04h in system nmi.
// [R07] an instruction fetch from peripheral space posts 1Eh in reset cause.
// [R08] reset cause reads 20h for a bad power key, 24h for fll unlock; 26h to 3Eh are reserved.
// [R09] system nmi reads 02h on supervisor low-power reset entry.
// [R10] system nmi reads 12h on a vacant memory access.
// [R11] system nmi reads 14h on mailbox input and 16h when mailbox output was taken.
// [R12] system nmi reads 18h on a correctable nvm error; 1Ah to 1Eh are reserved.
// [R13] user nmi reads 02h on pin nmi or high supervisor event and 04h on oscillator fault.
// [R14] a mailbox lets the application and the debug link exchange data words.
// [R15] each vector reads 00h when idle, else the smallest pending code.
// [R16] reading a vector clears the source whose code it returned.
`include "srnv_params.svh"
`timescale 1ns/1ns
`default_nettype none
module srnv_top (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	// peripheral bus
	input  wire logic [15:0]       busAddr,
	input  wire logic              busRead,
	input  wire logic              busWrite,
	input  wire srnv_pkg::srnv_word_t busWdata,
	output var  srnv_pkg::srnv_word_t busRdata,
	// reset cause events, one-cycle pulses
	input  wire logic              supplyBrownout,
	input  wire logic              resetPinEvent,
	input  wire logic              softwareBrownoutRequest,
	input  wire logic              deepestLowPowerWake,
	input  wire logic              securityViolation,
	input  wire logic              highSupplySupervisorEvent,
	input  wire logic              softwarePoweronRequest,
	input  wire logic              watchdogExpiry,
	input  wire logic              watchdogKeyError,
	input  wire logic              nvmControllerKeyError,
	input  wire logic              nvmUncorrectable,
	input  wire logic              peripheralFetch,
	input  wire logic              powerMgmtKeyError,
	input  wire logic              fllUnlock,
	// system nmi events
	input  wire logic              supervisorLowPowerEntry,
	input  wire logic              vacantAccess,
	input  wire logic              nvmCorrectable,
	// user nmi events
	input  wire logic              pinNmi,
	input  wire logic              oscillatorFault,
	// debug mailbox side
	input  wire logic              dbgWrite,
	input  wire srnv_pkg::srnv_word_t dbgWdata,
	input  wire logic              dbgRead,
	output var  srnv_pkg::srnv_word_t dbgRdata,
	output logic                   dbgInFull,
	output logic                   dbgOutFull
);
	import srnv_pkg::*;

	// ************************************************************
	// pending flags
	// ************************************************************
	srnv_rc_vec_t  rcPend;
	srnv_nmi_vec_t snPend;
	srnv_nmi_vec_t unPend;
	srnv_rc_vec_t  rcHot;
	srnv_nmi_vec_t snHot;
	srnv_nmi_vec_t unHot;
	srnv_word_t    rcCode;
	srnv_word_t    snCode;
	srnv_word_t    unCode;
	srnv_rc_vec_t  rcSet;
	srnv_nmi_vec_t snSet;
	srnv_nmi_vec_t unSet;
	logic          rcRd;
	logic          snRd;
	logic          unRd;
	logic          mbInEvent;
	logic          mbOutEvent;

	assign rcRd = busRead && (busAddr == `SRNV_ADDR_RST_CAUSE);
	assign snRd = busRead && (busAddr == `SRNV_ADDR_SYS_NMI);
	assign unRd = busRead && (busAddr == `SRNV_ADDR_USER_NMI);

	// map event pulses onto priority slots
	always_comb begin
		rcSet = '0;
		rcSet[`SRNV_RC_BOR]      = supplyBrownout;            // R01
		rcSet[`SRNV_RC_PIN]      = resetPinEvent;             // R01
		rcSet[`SRNV_RC_SWBOR]    = softwareBrownoutRequest;   // R01
		rcSet[`SRNV_RC_LPM5]     = deepestLowPowerWake;       // R02
		rcSet[`SRNV_RC_SECV]     = securityViolation;         // R02
		rcSet[`SRNV_RC_SVSH]     = highSupplySupervisorEvent; // R02
		rcSet[`SRNV_RC_SWPOR]    = softwarePoweronRequest;    // R03
		rcSet[`SRNV_RC_WDT]      = watchdogExpiry;            // R04
		rcSet[`SRNV_RC_WDTKEY]   = watchdogKeyError;          // R05
		rcSet[`SRNV_RC_NVMKEY]   = nvmControllerKeyError;     // R05
		rcSet[`SRNV_RC_NVMUNC]   = nvmUncorrectable;          // R06
		rcSet[`SRNV_RC_PERFETCH] = peripheralFetch;           // R07
		rcSet[`SRNV_RC_PMMKEY]   = powerMgmtKeyError;         // R08
		rcSet[`SRNV_RC_FLL]      = fllUnlock;                 // R08
		snSet = '0;
		snSet[`SRNV_SN_SVSL]     = supervisorLowPowerEntry;   // R09
		snSet[`SRNV_SN_NVMUNC]   = nvmUncorrectable;          // R06
		snSet[`SRNV_SN_VACANT]   = vacantAccess;              // R10
		snSet[`SRNV_SN_MBIN]     = mbInEvent;                 // R11
		snSet[`SRNV_SN_MBOUT]    = mbOutEvent;                // R11
		snSet[`SRNV_SN_NVMCOR]   = nvmCorrectable;            // R12
		unSet = '0;
		// a high supervisor event is both a reset cause and a user nmi
		unSet[`SRNV_UN_PIN]      = pinNmi || highSupplySupervisorEvent; // R13
		unSet[`SRNV_UN_OSC]      = oscillatorFault;           // R13
	end

	// reserved slots never set, so their codes cannot appear (R08, R12)
	srnv_prio_enc #(.SLOTS(`SRNV_RC_SLOTS)) rcEnc (
		.pending(rcPend),
		.code   (rcCode),
		.oneHot (rcHot)
	);
	srnv_prio_enc #(.SLOTS(`SRNV_SN_SLOTS)) snEnc (
		.pending(snPend),
		.code   (snCode),
		.oneHot (snHot)
	);
	srnv_prio_enc #(.SLOTS(`SRNV_UN_SLOTS)) unEnc (
		.pending(unPend),
		.code   (unCode),
		.oneHot (unHot)
	);

	// read clears the returned source; a new event in the same cycle wins
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rcPend <= '0;
		end else begin
			rcPend <= (rcPend & ~(rcRd ? rcHot : '0)) | rcSet; // R16
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			snPend <= '0;
		end else begin
			snPend <= (snPend & ~(snRd ? snHot : '0)) | snSet; // R16
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			unPend <= '0;
		end else begin
			unPend <= (unPend & ~(unRd ? unHot : '0)) | unSet; // R16
		end
	end

	// ************************************************************
	// debug mailbox
	// ************************************************************
	srnv_word_t mbIn;
	logic       mbOutRd;
	logic       mbInRd;

	assign mbInRd  = busRead && (busAddr == `SRNV_ADDR_MBOX_IN);
	assign mbOutRd = dbgRead && dbgOutFull;
	assign mbInEvent  = dbgWrite;  // R11
	assign mbOutEvent = mbOutRd;   // R11

	// inbound word from the debug link; a new write overwrites an unread word
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			mbIn      <= `SRNV_NONE;
			dbgInFull <= 1'b0;
		end else if (dbgWrite) begin
			mbIn      <= dbgWdata; // R14
			dbgInFull <= 1'b1;
		end else if (mbInRd) begin
			dbgInFull <= 1'b0;
		end
	end

	// outbound word to the debug link
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			dbgRdata   <= `SRNV_NONE;
			dbgOutFull <= 1'b0;
		end else if (busWrite && (busAddr == `SRNV_ADDR_MBOX_OUT)) begin
			dbgRdata   <= busWdata; // R14
			dbgOutFull <= 1'b1;
		end else if (mbOutRd) begin
			dbgOutFull <= 1'b0;
		end
	end

	// ************************************************************
	// read data
	// ************************************************************
	// registered, so data shows one cycle after the read strobe
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			busRdata <= `SRNV_NONE;
		end else if (busRead) begin
			unique case (busAddr)
				`SRNV_ADDR_RST_CAUSE: busRdata <= rcCode; // R15
				`SRNV_ADDR_SYS_NMI:   busRdata <= snCode; // R15
				`SRNV_ADDR_USER_NMI:  busRdata <= unCode; // R15
				`SRNV_ADDR_MBOX_IN:   busRdata <= mbIn;
				`SRNV_ADDR_MBOX_OUT:  busRdata <= dbgRdata;
				default:              busRdata <= `SRNV_NONE;
			endcase
		end
	end
endmodule
`default_nettype wire

// File: test/srnv_props.sv
// checker for the vector unit: register answers, read data hold, mailbox flags
// assumes binding onto srnv_top, one clock domain
`timescale 1ns/1ns
`default_nettype none
module srnv_props (
	// clock and reset
	input wire logic                 sys_clk,
	input wire logic                 rstn,
	// bus and events
	input wire logic [15:0]          busAddr,
	input wire logic                 busRead,
	input wire logic                 busWrite,
	input wire srnv_pkg::srnv_word_t busWdata,
	input wire srnv_pkg::srnv_word_t busRdata,
	input wire logic                 supplyBrownout,
	input wire logic                 supervisorLowPowerEntry,
	input wire logic                 pinNmi,
	// mailbox
	input wire logic                 dbgWrite,
	input wire logic                 dbgRead,
	input wire srnv_pkg::srnv_word_t dbgRdata,
	input wire logic                 dbgInFull,
	input wire logic                 dbgOutFull
);
	import srnv_pkg::*;
	// ****
	// one domain, so one clocking and one reset for all
	// ****
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// top priority codes win whatever else is pending
	a_rc_top_code: assert property (
		supplyBrownout ##1 (busRead && busAddr == 16'h015e) |=> busRdata == 16'h0002)
		else $error("reset cause top code wrong");
	a_sn_top_code: assert property (
		supervisorLowPowerEntry ##1 (busRead && busAddr == 16'h015c) |=> busRdata == 16'h0002)
		else $error("system nmi top code wrong");
	a_un_top_code: assert property (
		pinNmi ##1 (busRead && busAddr == 16'h015a) |=> busRdata == 16'h0002)
		else $error("user nmi top code wrong");
	a_unmapped_zero: assert property (
		busRead && busAddr == 16'h0100 |=> busRdata == 16'h0000)
		else $error("unmapped read not zero");
	a_rdata_stands: assert property (
		!busRead |=> $stable(busRdata))
		else $error("read data moved without read");
	a_mbox_posted: assert property (
		busWrite && busAddr == 16'h0150 |=> dbgOutFull && dbgRdata == $past(busWdata))
		else $error("outbound word not posted");
	a_mbox_taken: assert property (
		dbgRead && dbgOutFull && !(busWrite && busAddr == 16'h0150) |=> !dbgOutFull)
		else $error("outbound flag not cleared");
	a_mbox_arrive: assert property (
		dbgWrite |=> dbgInFull)
		else $error("inbound flag not set");
endmodule
bind srnv_top srnv_props chk (
	.sys_clk                (sys_clk),
	.rstn                   (rstn),
	.busAddr                (busAddr),
	.busRead                (busRead),
	.busWrite               (busWrite),
	.busWdata               (busWdata),
	.busRdata               (busRdata),
	.supplyBrownout         (supplyBrownout),
	.supervisorLowPowerEntry(supervisorLowPowerEntry),
	.pinNmi                 (pinNmi),
	.dbgWrite               (dbgWrite),
	.dbgRead                (dbgRead),
	.dbgRdata               (dbgRdata),
	.dbgInFull              (dbgInFull),
	.dbgOutFull             (dbgOutFull)
);
`default_nettype wire

// File: test/srnv_dbg_model.sv
// debug link side of the mailbox: posts inbound words, takes outbound ones
// assumes the caller works at the falling edge of sys_clk
`timescale 1ns/1ns
`default_nettype none
module srnv_dbg_model (
	// clock and mailbox answers
	input  wire logic                 sys_clk,
	input  wire logic                 dbgOutFull,
	input  wire srnv_pkg::srnv_word_t dbgRdata,
	// requests
	output logic                      dbgWrite,
	output srnv_pkg::srnv_word_t      dbgWdata,
	output logic                      dbgRead,
	output srnv_pkg::srnv_word_t      taken
);
	import srnv_pkg::*;
	initial begin
		dbgWrite = 1'b0;
		dbgRead = 1'b0;
		dbgWdata = 16'h0000;
		taken = 16'h0000;
	end
	// data line shows the inverse afterwards so a stale word is never mistaken
	task automatic send(input srnv_word_t w);
		@(negedge sys_clk);
		dbgWrite = 1'b1;
		dbgWdata = w;
		@(negedge sys_clk);
		dbgWrite = 1'b0;
		dbgWdata = ~w;
	endtask
	task automatic take;
		@(negedge sys_clk);
		if (dbgOutFull === 1'b1) begin
			taken = dbgRdata;
			dbgRead = 1'b1;
		end
		@(negedge sys_clk);
		dbgRead = 1'b0;
	endtask
endmodule
`default_nettype wire

// File: test/tb.sv
// testbench for the vector unit: bus reads and writes, event pulses, mailbox traffic
// assumes design, checker and debug model compiled first
`timescale 1ns/1ns
`default_nettype none
module tb;
	import srnv_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic [15:0] busAddr = 16'h0000;
	logic        busRead = 1'b0;
	logic        busWrite = 1'b0;
	logic        dbgWrite, dbgRead, dbgInFull, dbgOutFull;
	logic [18:0] evt = 19'h00000;
	srnv_word_t  busWdata = 16'h0000;
	srnv_word_t  busRdata, dbgWdata, dbgRdata, taken;
	int          n_fail = 0;
	int          checks = 0;
	srnv_word_t  rcExp [15] = '{16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000a, 16'h000e,
		16'h0014, 16'h0016, 16'h0018, 16'h001a, 16'h001c, 16'h001e, 16'h0020, 16'h0024, 16'h0000};
	srnv_word_t  snExp [5] = '{16'h0002, 16'h0004, 16'h0012, 16'h0018, 16'h0000};
	always #50 sys_clk = ~sys_clk;
	srnv_top dut (.sys_clk(sys_clk), .rstn(rstn), .busAddr(busAddr), .busRead(busRead),
		.busWrite(busWrite), .busWdata(busWdata), .busRdata(busRdata),
		.supplyBrownout(evt[0]), .resetPinEvent(evt[1]), .softwareBrownoutRequest(evt[2]),
		.deepestLowPowerWake(evt[3]), .securityViolation(evt[4]),
		.highSupplySupervisorEvent(evt[5]), .softwarePoweronRequest(evt[6]),
		.watchdogExpiry(evt[7]), .watchdogKeyError(evt[8]), .nvmControllerKeyError(evt[9]),
		.nvmUncorrectable(evt[10]), .peripheralFetch(evt[11]), .powerMgmtKeyError(evt[12]),
		.fllUnlock(evt[13]), .supervisorLowPowerEntry(evt[14]), .vacantAccess(evt[15]),
		.nvmCorrectable(evt[16]), .pinNmi(evt[17]), .oscillatorFault(evt[18]),
		.dbgWrite(dbgWrite), .dbgWdata(dbgWdata), .dbgRead(dbgRead), .dbgRdata(dbgRdata),
		.dbgInFull(dbgInFull), .dbgOutFull(dbgOutFull));
	srnv_dbg_model dbg (.sys_clk(sys_clk), .dbgOutFull(dbgOutFull), .dbgRdata(dbgRdata),
		.dbgWrite(dbgWrite), .dbgWdata(dbgWdata), .dbgRead(dbgRead), .taken(taken));
	// ****
	// bus tasks and comparison
	// ****
	task automatic cmp(input srnv_word_t got, input srnv_word_t exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// read also ends any event pulse, so a read can follow a pulse directly
	task automatic rd(input logic [15:0] a, input srnv_word_t exp);
		@(negedge sys_clk);
		evt = 19'h00000;
		busRead = 1'b1;
		busAddr = a;
		@(negedge sys_clk);
		busRead = 1'b0;
		cmp(busRdata, exp);
	endtask
	task automatic wr(input logic [15:0] a, input srnv_word_t d);
		@(negedge sys_clk);
		busWrite = 1'b1;
		busAddr = a;
		busWdata = d;
		@(negedge sys_clk);
		busWrite = 1'b0;
	endtask
	task automatic pulse(input logic [18:0] m);
		@(negedge sys_clk);
		evt = m;
	endtask
	task automatic test_done;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// a hang is cut short and counted as a mismatch
	initial begin
		#2000000;
		n_fail++;
		test_done();
	end
	initial begin
		repeat (5) @(negedge sys_clk);
		rstn = 1'b1;
		pulse(19'h03fff);
		foreach (rcExp[i]) rd(16'h015e, rcExp[i]);
		pulse(19'h1c000);
		foreach (snExp[i]) rd(16'h015c, snExp[i]);
		pulse(19'h60000);
		rd(16'h015a, 16'h0002);
		rd(16'h015a, 16'h0004);
		rd(16'h015a, 16'h0000);
		wr(16'h0150, 16'h1234);
		cmp(dbgRdata, 16'h1234);
		cmp({15'h0000, dbgOutFull}, 16'h0001);
		rd(16'h0150, 16'h1234);
		dbg.take();
		cmp(taken, 16'h1234);
		cmp({15'h0000, dbgOutFull}, 16'h0000);
		dbg.send(16'habcd);
		cmp({15'h0000, dbgInFull}, 16'h0001);
		rd(16'h015c, 16'h0014);
		rd(16'h015c, 16'h0016);
		rd(16'h015c, 16'h0000);
		rd(16'h0152, 16'habcd);
		cmp({15'h0000, dbgInFull}, 16'h0000);
		rd(16'h0100, 16'h0000);
		wr(16'h015e, 16'h0002);
		rd(16'h015e, 16'h0000);
		// a high supervisor event alone posts a reset cause and a user nmi
		pulse(19'h00020);
		rd(16'h015a, 16'h0002);
		rd(16'h015e, 16'h000e);
		rd(16'h015e, 16'h0000);
		// mid-run reset with every event input pulsed and both mailbox words loaded
		wr(16'h0150, 16'h5a5a);
		rd(16'h0150, 16'h5a5a);
		dbg.send(16'h1111);
		pulse(19'h7ffff);
		@(negedge sys_clk);
		evt = 19'h00000;
		rstn = 1'b0;
		@(negedge sys_clk);
		cmp(busRdata, 16'h0000);
		cmp(dbgRdata, 16'h0000);
		cmp({14'h0000, dbgInFull, dbgOutFull}, 16'h0000);
		rstn = 1'b1;
		rd(16'h015e, 16'h0000);
		rd(16'h015c, 16'h0000);
		rd(16'h015a, 16'h0000);
		rd(16'h0152, 16'h0000);
		test_done();
	end
endmodule
`default_nettype wire
